// ---- otes_axis.sv ----
// one axis of the outside-threshold detector: compare, event flag, polarity flag
// assumes i_odr_tick is a one-cycle pulse from logic on the same clock
`timescale 1ns/10ps
`default_nettype none
module otes_axis
	import otes_pkg::*;
(
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst,
	// sample and settings
	input wire logic i_odr_tick,
	input wire logic i_enable,
	input wire logic i_relative,
	input wire logic i_latch_enable,
	input wire logic i_clear,
	input wire logic i_debounce_reached,
	input wire logic signed [DATA_W-1:0] i_sample,
	input wire logic signed [DATA_W-1:0] i_upper_threshold,
	input wire logic signed [DATA_W-1:0] i_lower_threshold,
	// results
	output logic o_hit,
	output logic o_event_flag,
	output logic o_polarity
);
	logic signed [DATA_W-1:0] prev_r;
	logic signed [DATA_W:0] value;
	logic hit_up;
	logic hit_lo;

	// delta is one bit wider so a full-scale swing cannot wrap
	always_comb begin
		if (i_relative) begin
			value = {i_sample[DATA_W-1], i_sample} - {prev_r[DATA_W-1], prev_r};
		end else begin
			value = {i_sample[DATA_W-1], i_sample};
		end
		// both sides signed, or a negative value would compare as a large one
		hit_up = value >=
			$signed({i_upper_threshold[DATA_W-1], i_upper_threshold});
		hit_lo = value <=
			$signed({i_lower_threshold[DATA_W-1], i_lower_threshold});
		o_hit = i_enable && (hit_up || hit_lo);
	end

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			prev_r <= '0;
		end else if (i_odr_tick) begin
			prev_r <= i_sample;
		end
	end

	// a new hit on the tick outranks a clear in the same cycle
	// only latch mode holds flags for a read to clear; otherwise they track the data
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			o_event_flag <= 1'b0;
		end else if (i_odr_tick && !i_enable) begin
			o_event_flag <= 1'b0;
		end else if (i_odr_tick && o_hit) begin
			o_event_flag <= 1'b1;
		end else if (i_odr_tick && !i_latch_enable) begin
			o_event_flag <= 1'b0;
		end else if (i_clear && i_latch_enable) begin
			o_event_flag <= 1'b0;
		end
	end

	// upper wins when both thresholds are met, e.g. with crossed thresholds
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			o_polarity <= 1'b0;
		end else if (i_odr_tick && o_hit && !o_event_flag) begin
			o_polarity <= hit_up;
		end else if (i_odr_tick && o_hit && !i_latch_enable && i_debounce_reached) begin
			o_polarity <= hit_up;
		end
	end

	flag_set_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		i_odr_tick && o_hit |=> o_event_flag)
		else $error("axis flag not set on hit");
	flag_inside_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		i_odr_tick && !hit_up && !hit_lo && !i_latch_enable |=> !o_event_flag)
		else $error("axis flag set while inside window");
	pol_capture_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		i_odr_tick && o_hit && !o_event_flag |=> o_polarity == $past(hit_up))
		else $error("polarity not captured on flag set");
	axis_off_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		i_odr_tick && !i_enable |=> !o_event_flag && $stable(o_polarity))
		else $error("disabled axis changed its flags");
endmodule
`default_nettype wire

// ---- otes_host.sv ----
// host model: issues status register reads and captures the answer
// assumes the device answers one cycle after it takes the read
`timescale 1ns/10ps
`default_nettype none
module otes_host (
	// clock and request
	input wire logic i_core_clk,
	input wire logic i_go,
	input wire logic [7:0] i_addr,
	// device side
	input wire logic [7:0] i_rd_data,
	output var logic o_rd_en,
	output var logic [7:0] o_rd_addr,
	// captured answer
	output logic [7:0] o_data
);
	logic vld_r;
	initial begin
		o_rd_en = 1'b0;
		o_rd_addr = 8'h00;
		vld_r = 1'b0;
	end
	// a released address shows the inverse, so a stale value cannot keep decoding
	always @(posedge i_core_clk) begin
		o_rd_en <= i_go;
		o_rd_addr <= i_go ? i_addr : ~i_addr;
		vld_r <= o_rd_en;
	end
	assign o_data = vld_r ? i_rd_data : 8'h00;
endmodule
`default_nettype wire

// ---- otes_pkg.sv ----
// constants for the outside-threshold event status block
// assumes a 12-bit signed sample per axis and one output-data-rate tick per sample
package otes_pkg;
	localparam int DATA_W = 12;
	localparam int DBCNT_W = 8;
	localparam logic [7:0] STATUS_OFFSET = 8'h2d;
	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam int ACTIVE_BIT = 7;
	localparam int UNUSED_BIT = 6;
	// event/polarity pair of axis n sits at bits (5-2n) and (4-2n)
	localparam int X_EF_BIT = 5;
	localparam int X_POL_BIT = 4;
	localparam int Y_EF_BIT = 3;
	localparam int Y_POL_BIT = 2;
	localparam int Z_EF_BIT = 1;
	localparam int Z_POL_BIT = 0;
	localparam int AXES = 3;
endpackage

// ---- otes_top.sv ----
// outside-threshold event status: three axis detectors, debounce, status read port
// assumes all inputs come from logic on i_core_clk; the serial interface decodes reads
// How it works
// - axis flag sets when value is at or beyond upper or lower threshold
// - axis flag clears on a tick while value lies strictly between the thresholds, except a latched flag holds until read
// - polarity bit beside each flag: one upper, zero lower threshold met
// - active flag sets once OR of enabled axis hits lasts debounce count periods
// - active flag reads zero when all enabled axes lie inside the window
// - only enabled axes take part; no enables means detection is off
// - each axis flag is evaluated only while its enable bit is one
// - absolute mode compares the sample, relative mode compares its change
// - wake option restarts the auto-sleep timer each tick while active
// - status: active bit 7, bit 6 zero, X/Y/Z pairs in 5..0, read-only
// - active flag can be routed to either interrupt pin
// - polarity taken when its flag sets, and in plain mode again once debounced; meaningful only while flag is one
`timescale 1ns/10ps
`default_nettype none
module otes_top
	import otes_pkg::*;
(
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst,
	// samples, one set per output-data-rate tick
	input wire logic i_odr_tick,
	input wire logic signed [DATA_W-1:0] i_x_sample,
	input wire logic signed [DATA_W-1:0] i_y_sample,
	input wire logic signed [DATA_W-1:0] i_z_sample,
	// configuration held elsewhere
	input wire logic i_x_outside_enable,
	input wire logic i_y_outside_enable,
	input wire logic i_z_outside_enable,
	input wire logic i_relative_mode,
	input wire logic i_outside_event_latch_enable,
	input wire logic signed [DATA_W-1:0] i_upper_threshold,
	input wire logic signed [DATA_W-1:0] i_lower_threshold,
	input wire logic [DBCNT_W-1:0] i_outside_debounce_count,
	input wire logic i_wake_on_outside_event,
	input wire logic i_route_interrupt_pin_one,
	input wire logic i_route_interrupt_pin_two,
	// register read port
	input wire logic i_rd_en,
	input wire logic [7:0] i_rd_addr,
	output logic [7:0] o_rd_data,
	// events
	output logic o_outside_event_active,
	output logic o_interrupt_pin_one,
	output logic o_interrupt_pin_two,
	output logic o_wake_timer_restart
);
	logic [AXES-1:0] enable;
	logic [AXES-1:0] hit;
	logic [AXES-1:0] event_flag;
	logic [AXES-1:0] polarity;
	logic signed [DATA_W-1:0] sample [AXES];
	logic [DBCNT_W-1:0] dbcnt_r;
	logic [DBCNT_W-1:0] dbcnt_nxt;
	logic any_hit;
	logic debounce_reached;
	logic status_read;
	logic [7:0] status;

	assign enable = {i_x_outside_enable, i_y_outside_enable, i_z_outside_enable};
	assign sample[2] = i_x_sample;
	assign sample[1] = i_y_sample;
	assign sample[0] = i_z_sample;
	assign status_read = i_rd_en && (i_rd_addr == STATUS_OFFSET);

	// index 2 is X, 1 is Y, 0 is Z so the status bits fall out of the index
	generate
		for (genvar a = 0; a < AXES; a++) begin : g_axis
			otes_axis u_axis (
				.i_core_clk(i_core_clk),
				.i_rst(i_rst),
				.i_odr_tick(i_odr_tick),
				.i_enable(enable[a]),
				.i_relative(i_relative_mode),
				.i_latch_enable(i_outside_event_latch_enable),
				.i_clear(status_read),
				.i_debounce_reached(debounce_reached),
				.i_sample(sample[a]),
				.i_upper_threshold(i_upper_threshold),
				.i_lower_threshold(i_lower_threshold),
				.o_hit(hit[a]),
				.o_event_flag(event_flag[a]),
				.o_polarity(polarity[a])
			);
		end
	endgenerate

	// disabled axes never hit, so with no enables the detector stays idle
	always_comb begin
		any_hit = |(hit & enable);
		if (dbcnt_r == {DBCNT_W{1'b1}}) begin
			dbcnt_nxt = dbcnt_r;
		end else begin
			dbcnt_nxt = dbcnt_r + 1'b1;
		end
		debounce_reached = any_hit && (dbcnt_nxt >= i_outside_debounce_count);
		// bit 6 keeps its reset value of zero
		status = STATUS_RESET;
		status[ACTIVE_BIT] = o_outside_event_active;
		status[X_EF_BIT] = event_flag[2];
		status[X_POL_BIT] = polarity[2];
		status[Y_EF_BIT] = event_flag[1];
		status[Y_POL_BIT] = polarity[1];
		status[Z_EF_BIT] = event_flag[0];
		status[Z_POL_BIT] = polarity[0];
	end

	// counter saturates so a long event cannot wrap back under the count
	// a tick with no hit restarts the count, even while a latched axis flag still stands
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			dbcnt_r <= '0;
		end else if (i_odr_tick) begin
			dbcnt_r <= any_hit ? dbcnt_nxt : '0;
		end
	end

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			o_outside_event_active <= 1'b0;
		end else if (i_odr_tick) begin
			o_outside_event_active <= debounce_reached;
		end
	end

	// restart is judged on the active level held over the data-rate period now ending
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			o_wake_timer_restart <= 1'b0;
		end else begin
			o_wake_timer_restart <= i_odr_tick && i_wake_on_outside_event
				&& o_outside_event_active;
		end
	end

	// pins follow the active flag one cycle late and never react to a read
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			o_interrupt_pin_one <= 1'b0;
			o_interrupt_pin_two <= 1'b0;
		end else begin
			o_interrupt_pin_one <= i_route_interrupt_pin_one && o_outside_event_active;
			o_interrupt_pin_two <= i_route_interrupt_pin_two && o_outside_event_active;
		end
	end

	// unmapped addresses read zero; writes do not exist on this port
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			o_rd_data <= STATUS_RESET;
		end else if (status_read) begin
			o_rd_data <= status;
		end else begin
			o_rd_data <= 8'h00;
		end
	end

	active_set_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		i_odr_tick && any_hit && (dbcnt_nxt >= i_outside_debounce_count)
		|=> o_outside_event_active)
		else $error("active flag not set after debounce");
	active_wait_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		i_odr_tick && (dbcnt_nxt < i_outside_debounce_count) |=> !o_outside_event_active)
		else $error("active flag set before debounce count");
	active_clear_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		i_odr_tick && !any_hit |=> !o_outside_event_active
		##1 ($past(i_odr_tick) || !o_outside_event_active))
		else $error("active flag set while all axes inside");
	no_enable_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		i_odr_tick && enable == 3'b000 |=> !o_outside_event_active && event_flag == 3'b000)
		else $error("detection active with no axis enabled");
	wake_restart_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		o_wake_timer_restart |-> $past(o_outside_event_active) && $past(i_wake_on_outside_event)
		&& $past(i_odr_tick))
		else $error("wake restart without active flag");
	status_read_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		status_read |=> o_rd_data == $past(status) && !o_rd_data[UNUSED_BIT])
		else $error("status read returned wrong value");
	unmapped_read_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		!status_read |=> o_rd_data == 8'h00)
		else $error("unmapped read not zero");
	int_route_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		##1 o_interrupt_pin_two == ($past(i_route_interrupt_pin_two)
		&& $past(o_outside_event_active)))
		else $error("interrupt pin two misrouted");

	// debounce counter, wake, routing and per-axis flags
	int_one_route_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		##1 o_interrupt_pin_one == ($past(i_route_interrupt_pin_one)
		&& $past(o_outside_event_active)))
		else $error("interrupt pin one misrouted");
	wake_set_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		i_odr_tick && i_wake_on_outside_event && o_outside_event_active
		|=> o_wake_timer_restart)
		else $error("wake restart missing while active");
	wake_off_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		!i_wake_on_outside_event |=> !o_wake_timer_restart)
		else $error("wake restart with wake option off");
	count_clear_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		i_odr_tick && !any_hit |=> dbcnt_r == '0)
		else $error("debounce count kept after a quiet tick");
	count_hold_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		!i_odr_tick |=> $stable(dbcnt_r))
		else $error("debounce count moved between ticks");
	flag_follow_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		i_odr_tick && !i_outside_event_latch_enable |=> event_flag == $past(hit))
		else $error("axis flags do not follow the data");
	pol_hold_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		!i_odr_tick |=> $stable(polarity))
		else $error("polarity changed between ticks");

	active_rise_c: cover property (@(posedge i_core_clk) disable iff (i_rst)
		$rose(o_outside_event_active));
	wake_c: cover property (@(posedge i_core_clk) disable iff (i_rst) o_wake_timer_restart);
	read_event_c: cover property (@(posedge i_core_clk) disable iff (i_rst)
		status_read && |event_flag);
	relative_hit_c: cover property (@(posedge i_core_clk) disable iff (i_rst)
		i_odr_tick && i_relative_mode && any_hit);
	latch_clear_c: cover property (@(posedge i_core_clk) disable iff (i_rst)
		status_read && i_outside_event_latch_enable && |event_flag);
endmodule
`default_nettype wire

// ---- tb_outside_threshold_event_status.sv ----
// self-checking bench for otes_top against an integer reference model
// assumes otes_host stands in for the processor reading the status register
`timescale 1ns/10ps
`default_nettype none
module tb_outside_threshold_event_status;
	import otes_pkg::*;
	logic i_core_clk = 1'b0, i_rst = 1'b1, tick = 1'b0, rel = 1'b0, latch = 1'b0;
	logic wake = 1'b0, go = 1'b0, rd_en, interrupt_pin_one, interrupt_pin_two, wk, act;
	logic signed [DATA_W-1:0] sx = '0, sy = '0, sz = '0, up = 12'sd100, lo = -12'sd100;
	logic [2:0] en = 3'h0, mf = 3'h0, mp = 3'h0;
	logic [1:0] route = 2'h0;
	logic [7:0] db = 8'h00, addr = 8'h00, rd_addr, rd_data, hdata;
	logic ma = 1'b0;
	int fail_count = 0, n_tests = 0, cnt = 0, prev[3] = '{0, 0, 0};
	always #12.5 i_core_clk = ~i_core_clk;
	otes_top DUT (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_odr_tick(tick),
		.i_x_sample(sx), .i_y_sample(sy), .i_z_sample(sz),
		.i_x_outside_enable(en[0]), .i_y_outside_enable(en[1]), .i_z_outside_enable(en[2]),
		.i_relative_mode(rel), .i_outside_event_latch_enable(latch),
		.i_upper_threshold(up), .i_lower_threshold(lo), .i_outside_debounce_count(db),
		.i_wake_on_outside_event(wake), .i_route_interrupt_pin_one(route[0]),
		.i_route_interrupt_pin_two(route[1]), .i_rd_en(rd_en), .i_rd_addr(rd_addr),
		.o_rd_data(rd_data), .o_outside_event_active(act), .o_interrupt_pin_one(interrupt_pin_one),
		.o_interrupt_pin_two(interrupt_pin_two), .o_wake_timer_restart(wk));
	otes_host host (.i_core_clk(i_core_clk), .i_go(go), .i_addr(addr), .i_rd_data(rd_data),
		.o_rd_en(rd_en), .o_rd_addr(rd_addr), .o_data(hdata));
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fail_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// mid-run reset: every output must read zero and the model starts over
	task automatic apply_reset;
		@(posedge i_core_clk);
		i_rst <= 1'b1;
		repeat (3) @(posedge i_core_clk);
		i_rst <= 1'b0;
		@(negedge i_core_clk);
		check({act, interrupt_pin_two, interrupt_pin_one, wk, 4'h0}, 8'h00);
		check(rd_data, STATUS_RESET);
		mf = 3'h0;
		cnt = 0;
		ma = 1'b0;
		prev = '{0, 0, 0};
	endtask
	// one output-data-rate tick with random settings, then a read of the status register or of unmapped 8'h2e
	task automatic step(input logic all_off);
		int r[3], v[3], h[3], any;
		logic [7:0] a, m, k;
		logic pa;
		for (int i = 0; i < 3; i++) r[i] = int'($urandom_range(260)) - 130;
		a = ($urandom_range(3) == 0) ? 8'h2e : STATUS_OFFSET;
		@(posedge i_core_clk);
		tick <= 1'b1;
		sx <= DATA_W'(r[0]);
		sy <= DATA_W'(r[1]);
		sz <= DATA_W'(r[2]);
		en <= all_off ? 3'h0 : 3'($urandom_range(7));
		rel <= 1'($urandom_range(1));
		db <= 8'($urandom_range(3));
		wake <= 1'($urandom_range(1));
		route <= 2'($urandom_range(3));
		@(posedge i_core_clk);
		tick <= 1'b0;
		go <= 1'b1;
		addr <= a;
		any = 0;
		for (int i = 0; i < 3; i++) begin
			v[i] = rel ? r[i] - prev[i] : r[i];
			prev[i] = r[i];
			h[i] = en[i] && (v[i] >= up || v[i] <= lo);
			any |= h[i];
		end
		pa = ma;
		cnt = any ? (cnt < 255 ? cnt + 1 : 255) : 0;
		ma = any && cnt >= db;
		// polarity taken when the flag sets, and in plain mode again once debounced
		for (int i = 0; i < 3; i++) begin
			if (h[i] && (!mf[i] || (!latch && ma))) mp[i] = v[i] >= up;
			mf[i] = en[i] && (h[i] || (latch && mf[i]));
		end
		// the restart pulse stands only in the cycle after the tick edge
		@(negedge i_core_clk);
		check(8'(wk), 8'(wake & pa));
		@(posedge i_core_clk);
		go <= 1'b0;
		@(negedge i_core_clk);
		check(8'(act), 8'(ma));
		check(8'({interrupt_pin_two, interrupt_pin_one}), 8'(route & {2{ma}}));
		@(negedge i_core_clk);
		// a polarity bit means something only while its flag is set
		m = (a == STATUS_OFFSET) ? 8'hea | {3'h0, mf[0], 1'b0, mf[1], 1'b0, mf[2]} : 8'hff;
		k = (a == STATUS_OFFSET) ?
			{ma, 1'b0, mf[0], mp[0], mf[1], mp[1], mf[2], mp[2]} : 8'h00;
		check(hdata & m, k & m);
		if (a == STATUS_OFFSET && latch)
			mf = 3'h0;
	endtask
	initial begin
		cnt = $urandom(32'h071fd2b4);
		cnt = 0;
		repeat (3) @(posedge i_core_clk);
		i_rst <= 1'b0;
		for (int i = 0; i < 20; i++) step(1'b1);
		$display("test all axes off done");
		for (int p = 0; p < 2; p++) begin
			if (p == 1) begin
				apply_reset();
				$display("test mid-run reset done");
			end
			@(posedge i_core_clk);
			latch <= p[0];
			for (int i = 0; i < 300; i++) step(1'b0);
			$display("test latch mode %0d done", p);
		end
		end_sim();
	end
	// the tests need about 2500 cycles; the limit allows about 10000
	initial begin
		#250000;
		fail_count++;
		end_sim();
	end
endmodule
`default_nettype wire
